/* shared/vfp_regs.svh */
`ifndef VFP_REGS_SVH
`define VFP_REGS_SVH
// How it works
// - body opens with the descriptor word, then optionally tagged units.
// - descriptor bits 31 to 27 stay reserved.
// - bit 26 picks audio coding, 0 layer audio, 1 advanced audio.
// - bits 25 to 22 carry the video tier code, level 1 to 5.1.
// - bit 21 is set when key-length-value metadata rides in the stream.
// - bit 20 is set when the stream clock follows the relative counter.
// - the 27 MHz stream clock is slaved to the relative counter ticks.
// - stream clock value is 33-bit base times 300 plus 9-bit extension.
// - bit 19 is set when every unit gets a time tag.
// - bits 18 to 15 carry the video profile code, above 0110 reserved.
// - bit 14 is set when embedded time is in the video data.
// - bit 13 is 0 for constant rate and 1 for variable rate.
// - bit 12 is 0 for transport stream and 1 for program stream.
// - bits 11 to 0 hold the binary unit count of the body.
// - only whole units per packet; unknown count is written as zero.
// - a 64-bit tag precedes each unit, low word first, then high word.
// - counter mode tag holds 48-bit counter, high 16 bits zero.
// - absolute mode tag holds absolute time in the selected format.

`define VFP_OFF_CTRL      8'h00
`define VFP_OFF_DESC_CFG  8'h04
`define VFP_OFF_UNITS     8'h08
`define VFP_OFF_STATUS    8'h0C
`define VFP_OFF_SCR_LO    8'h10
`define VFP_OFF_SCR_HI    8'h14
`define VFP_OFF_PKT_CNT   8'h18

`define VFP_CTRL_ENABLE   0
`define VFP_CTRL_HDR_EN   1
`define VFP_CTRL_ABS_SEL  2
`define VFP_CTRL_FMT_LO   3
`define VFP_CTRL_FMT_HI   4
`define VFP_CTRL_SCR_EN   5

`define VFP_DESC_RSV_HI   31
`define VFP_DESC_RSV_LO   27
`define VFP_DESC_AUDIO    26
`define VFP_DESC_TIER_HI  25
`define VFP_DESC_TIER_LO  22
`define VFP_DESC_META     21
`define VFP_DESC_LOCK     20
`define VFP_DESC_HDR      19
`define VFP_DESC_PROF_HI  18
`define VFP_DESC_PROF_LO  15
`define VFP_DESC_EMB      14
`define VFP_DESC_RATE     13
`define VFP_DESC_KIND     12
`define VFP_DESC_CNT_HI   11
`define VFP_DESC_CNT_LO   0

`define VFP_DESC_CFG_MASK 32'h07E7_F000
`define VFP_PROF_MAX      4'h6
`define VFP_PROF_SAFE     4'h0
`define VFP_STAT_RSVPROF  5

`define VFP_SCR_EXT_MOD   9'h12C
`define VFP_SCR_FRAC_ADD  6'h1B
`define VFP_SCR_FRAC_DIV  6'h0A
`define VFP_SCR_FRAC_TOP  6'h1E
`endif

/* shared/vfp_pkg.sv */
package vfp_pkg;
  typedef enum logic [5:0] {
    ST_IDLE  = 6'h01,
    ST_DESC  = 6'h02,
    ST_TAGLO = 6'h04,
    ST_TAGHI = 6'h08,
    ST_UNIT  = 6'h10,
    ST_GAP   = 6'h20
  } vfp_state_type;
endpackage : vfp_pkg

/* rtl/vfp_packet_framer.sv */
`timescale 1ns/1ps
`include "vfp_regs.svh"
module vfp_packet_framer
  import vfp_pkg::*;
#(
  parameter int DATA_W = 32,
  parameter int CNT_W  = 12
) (
  input  wire logic              sys_clk,
  input  wire logic              rst_n,
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [7:0]        paddr,
  input  wire logic [31:0]       pwdata,
  output logic [31:0]            prdata,
  output logic                   pready,
  output logic                   pslverr,
  input  wire logic              unitValid,
  output logic                   unitReady,
  input  wire logic [DATA_W-1:0] unitData,
  input  wire logic              unitLast,
  input  wire logic              unitPktEnd,
  output logic                   bodyValid,
  input  wire logic              bodyReady,
  output logic [DATA_W-1:0]      bodyData,
  output logic                   bodyFirst,
  output logic                   bodyLast,
  input  wire logic              rtcTick,
  input  wire logic [47:0]       rtcTime,
  input  wire logic [63:0]       absTime,
  output logic                   absTimeSel,
  output logic [1:0]             timeFormat,
  output logic [32:0]            scrBase,
  output logic [8:0]             scrExt,
  output logic [41:0]            scrValue
);

  vfp_state_type     state_ff;
  vfp_state_type     nxt_state;
  logic [5:0]        ctrl_ff;
  logic [31:0]       descCfg_ff;
  logic [CNT_W-1:0]  unitsCfg_ff;
  logic [CNT_W-1:0]  pktUnits_ff;
  logic [CNT_W-1:0]  unitsDone_ff;
  logic [31:0]       pktCount_ff;
  logic              rsvProf_ff;
  logic [63:0]       timeLatch_ff;
  logic              outValid_ff;
  logic [DATA_W-1:0] outData_ff;
  logic              outFirst_ff;
  logic              outLast_ff;
  logic [3:0]        frac_ff;
  logic [32:0]       scrBase_ff;
  logic [8:0]        scrExt_ff;
  logic [41:0]       scrValue_ff;

  logic              apbWr;
  logic              canLoad;
  logic              unitTake;
  logic              unitEnd;
  logic              pktEnd;
  logic [3:0]        profSafe;
  logic [31:0]       descWord;
  logic [63:0]       tagNow;
  logic [5:0]        fracSum;
  logic [1:0]        scrInc;
  logic [9:0]        extSum;

  // apb slave, zero wait states
  assign apbWr   = psel && penable && pwrite;
  assign pready  = 1'b1;

  always_comb begin
    pslverr = 1'b0;
    if (psel && penable) begin
      unique case (paddr)
        `VFP_OFF_CTRL, `VFP_OFF_DESC_CFG, `VFP_OFF_UNITS,
        `VFP_OFF_STATUS, `VFP_OFF_SCR_LO, `VFP_OFF_SCR_HI,
        `VFP_OFF_PKT_CNT: pslverr = 1'b0;
        default:          pslverr = 1'b1;
      endcase
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      ctrl_ff     <= 6'h00;
      descCfg_ff  <= 32'h0000_0000;
      unitsCfg_ff <= '0;
    end else if (apbWr) begin
      if (paddr == `VFP_OFF_CTRL) begin
        ctrl_ff <= pwdata[5:0];
      end
      if (paddr == `VFP_OFF_DESC_CFG) begin
        descCfg_ff <= pwdata & `VFP_DESC_CFG_MASK;
      end
      if (paddr == `VFP_OFF_UNITS) begin
        unitsCfg_ff <= pwdata[CNT_W-1:0];
      end
    end
  end

  // sticky flag: a new reserved profile write wins over the clear
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      rsvProf_ff <= 1'b0;
    end else if (apbWr && paddr == `VFP_OFF_DESC_CFG &&
                 pwdata[`VFP_DESC_PROF_HI:`VFP_DESC_PROF_LO] >
                 `VFP_PROF_MAX) begin
      rsvProf_ff <= 1'b1;
    end else if (apbWr && paddr == `VFP_OFF_STATUS &&
                 pwdata[`VFP_STAT_RSVPROF]) begin
      rsvProf_ff <= 1'b0;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      prdata <= 32'h0000_0000;
    end else if (psel && !penable && !pwrite) begin
      unique case (paddr)
        `VFP_OFF_CTRL:     prdata <= {26'h000_0000, ctrl_ff};
        `VFP_OFF_DESC_CFG: prdata <= descCfg_ff;
        `VFP_OFF_UNITS:    prdata <= {{(32-CNT_W){1'b0}}, unitsCfg_ff};
        `VFP_OFF_STATUS:   prdata <= {4'h0, unitsDone_ff, 10'h000,
                                      rsvProf_ff, 5'h00} |
                                     {26'h000_0000, state_ff};
        `VFP_OFF_SCR_LO:   prdata <= scrValue_ff[31:0];
        `VFP_OFF_SCR_HI:   prdata <= {22'h00_0000, scrValue_ff[41:32]};
        `VFP_OFF_PKT_CNT:  prdata <= pktCount_ff;
        default:           prdata <= 32'h0000_0000;
      endcase
    end
  end

  assign absTimeSel = ctrl_ff[`VFP_CTRL_ABS_SEL];
  assign timeFormat = ctrl_ff[`VFP_CTRL_FMT_HI:`VFP_CTRL_FMT_LO];

  // stream clock slaved to the counter
  // each 10 MHz tick advances the 27 MHz count by 2.7 on average
  assign fracSum = {2'b00, frac_ff} + `VFP_SCR_FRAC_ADD;
  assign scrInc  = (fracSum >= `VFP_SCR_FRAC_TOP) ? 2'd3 : 2'd2;
  assign extSum  = {1'b0, scrExt_ff} + {8'h00, scrInc};

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      frac_ff    <= 4'h0;
      scrBase_ff <= '0;
      scrExt_ff  <= 9'h000;
    end else if (ctrl_ff[`VFP_CTRL_SCR_EN] && rtcTick) begin
      frac_ff <= 4'(fracSum - 6'(scrInc) * `VFP_SCR_FRAC_DIV);
      if (extSum >= {1'b0, `VFP_SCR_EXT_MOD}) begin
        scrExt_ff  <= 9'(extSum - {1'b0, `VFP_SCR_EXT_MOD});
        scrBase_ff <= scrBase_ff + 33'd1;
      end else begin
        scrExt_ff <= extSum[8:0];
      end
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      scrValue_ff <= '0;
    end else begin
      scrValue_ff <= 42'(scrBase_ff) * 42'd300 + 42'(scrExt_ff);
    end
  end

  assign scrBase  = scrBase_ff;
  assign scrExt   = scrExt_ff;
  assign scrValue = scrValue_ff;

  // descriptor and tag words
  assign profSafe =
    (descCfg_ff[`VFP_DESC_PROF_HI:`VFP_DESC_PROF_LO] > `VFP_PROF_MAX) ?
    `VFP_PROF_SAFE : descCfg_ff[`VFP_DESC_PROF_HI:`VFP_DESC_PROF_LO];

  always_comb begin
    descWord = 32'h0000_0000;
    descWord[`VFP_DESC_AUDIO] = descCfg_ff[`VFP_DESC_AUDIO];
    descWord[`VFP_DESC_TIER_HI:`VFP_DESC_TIER_LO] =
      descCfg_ff[`VFP_DESC_TIER_HI:`VFP_DESC_TIER_LO];
    descWord[`VFP_DESC_META] = descCfg_ff[`VFP_DESC_META];
    descWord[`VFP_DESC_LOCK] = ctrl_ff[`VFP_CTRL_SCR_EN];
    descWord[`VFP_DESC_HDR]  = ctrl_ff[`VFP_CTRL_HDR_EN];
    descWord[`VFP_DESC_PROF_HI:`VFP_DESC_PROF_LO] = profSafe;
    descWord[`VFP_DESC_EMB]  = descCfg_ff[`VFP_DESC_EMB];
    descWord[`VFP_DESC_RATE] = descCfg_ff[`VFP_DESC_RATE];
    descWord[`VFP_DESC_KIND] = descCfg_ff[`VFP_DESC_KIND];
    descWord[`VFP_DESC_CNT_HI:`VFP_DESC_CNT_LO] = pktUnits_ff;
  end

  // time caught when the unit's first word is already waiting
  assign tagNow = absTimeSel ? absTime
                             : {16'h0000, rtcTime};

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      timeLatch_ff <= '0;
    end else if ((state_ff == ST_IDLE && ctrl_ff[`VFP_CTRL_ENABLE] ||
                  state_ff == ST_GAP) && unitValid) begin
      timeLatch_ff <= tagNow;
    end
  end

  // framing state machine
  assign canLoad  = !outValid_ff || bodyReady;
  assign unitTake = state_ff == ST_UNIT && unitValid && canLoad;
  assign unitEnd  = unitTake && unitLast;
  // count zero means unknown: the encoder closes the packet
  assign pktEnd   = unitEnd &&
                    ((pktUnits_ff != '0) ?
                     (unitsDone_ff + 1'b1 == pktUnits_ff) :
                     unitPktEnd);
  assign unitReady = state_ff == ST_UNIT && canLoad;

  always_comb begin
    nxt_state = state_ff;
    unique case (state_ff)
      ST_IDLE: begin
        if (ctrl_ff[`VFP_CTRL_ENABLE] && unitValid) begin
          nxt_state = ST_DESC;
        end
      end
      ST_DESC: begin
        if (canLoad) begin
          nxt_state = ctrl_ff[`VFP_CTRL_HDR_EN] ? ST_TAGLO : ST_UNIT;
        end
      end
      ST_TAGLO: begin
        if (canLoad) begin
          nxt_state = ST_TAGHI;
        end
      end
      ST_TAGHI: begin
        if (canLoad) begin
          nxt_state = ST_UNIT;
        end
      end
      ST_UNIT: begin
        if (pktEnd) begin
          nxt_state = ST_IDLE;
        end else if (unitEnd) begin
          nxt_state = ST_GAP;
        end
      end
      ST_GAP: begin
        if (unitValid) begin
          nxt_state = ctrl_ff[`VFP_CTRL_HDR_EN] ? ST_TAGLO : ST_UNIT;
        end
      end
    endcase
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      state_ff <= ST_IDLE;
    end else begin
      state_ff <= nxt_state;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      pktUnits_ff  <= '0;
      unitsDone_ff <= '0;
      pktCount_ff  <= 32'h0000_0000;
    end else begin
      if (state_ff == ST_IDLE && nxt_state == ST_DESC) begin
        pktUnits_ff  <= unitsCfg_ff;
        unitsDone_ff <= '0;
      end else if (unitEnd) begin
        unitsDone_ff <= unitsDone_ff + 1'b1;
      end
      if (pktEnd) begin
        pktCount_ff <= pktCount_ff + 32'd1;
      end
    end
  end

  // single output register keeps data outputs on flops
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      outValid_ff <= 1'b0;
      outData_ff  <= '0;
      outFirst_ff <= 1'b0;
      outLast_ff  <= 1'b0;
    end else if (canLoad) begin
      outValid_ff <= 1'b0;
      outFirst_ff <= 1'b0;
      outLast_ff  <= 1'b0;
      unique case (state_ff)
        ST_DESC: begin
          outValid_ff <= 1'b1;
          outData_ff  <= descWord;
          outFirst_ff <= 1'b1;
        end
        ST_TAGLO: begin
          outValid_ff <= 1'b1;
          outData_ff  <= timeLatch_ff[31:0];
        end
        ST_TAGHI: begin
          outValid_ff <= 1'b1;
          outData_ff  <= timeLatch_ff[63:32];
        end
        ST_UNIT: begin
          if (unitValid) begin
            outValid_ff <= 1'b1;
            outData_ff  <= unitData;
            outLast_ff  <= pktEnd;
          end
        end
        default: begin
          outValid_ff <= 1'b0;
        end
      endcase
    end
  end

  assign bodyValid = outValid_ff;
  assign bodyData  = outData_ff;
  assign bodyFirst = outFirst_ff;
  assign bodyLast  = outLast_ff;

  sequence s_hi_loaded;
    state_ff == ST_TAGHI && canLoad;
  endsequence

  property p_desc_reserved;
    @(posedge sys_clk) disable iff (!rst_n)
      bodyValid && bodyFirst |->
        bodyData[`VFP_DESC_RSV_HI:`VFP_DESC_RSV_LO] == 5'h00;
  endproperty
  a_desc_reserved: assert property (p_desc_reserved)
    else $error("reserved descriptor bits not zero");
  property p_profile_legal;
    @(posedge sys_clk) disable iff (!rst_n)
      bodyValid && bodyFirst |->
        bodyData[`VFP_DESC_PROF_HI:`VFP_DESC_PROF_LO] <= `VFP_PROF_MAX;
  endproperty
  a_profile_legal: assert property (p_profile_legal)
    else $error("reserved profile code emitted");
  property p_lock_flag;
    @(posedge sys_clk) disable iff (!rst_n)
      bodyValid && bodyFirst |->
        bodyData[`VFP_DESC_LOCK] == ctrl_ff[`VFP_CTRL_SCR_EN] &&
        bodyData[`VFP_DESC_HDR] == ctrl_ff[`VFP_CTRL_HDR_EN];
  endproperty
  a_lock_flag: assert property (p_lock_flag)
    else $error("lock or header flag disagrees with control");
  property p_count_field;
    @(posedge sys_clk) disable iff (!rst_n)
      bodyValid && bodyFirst |->
        bodyData[`VFP_DESC_CNT_HI:`VFP_DESC_CNT_LO] == pktUnits_ff;
  endproperty
  a_count_field: assert property (p_count_field)
    else $error("unit count field wrong");

  // low word still on the output when the high word loads
  property p_tag_order;
    @(posedge sys_clk) disable iff (!rst_n)
      s_hi_loaded |-> bodyData == timeLatch_ff[31:0] ##1
        state_ff == ST_UNIT && bodyData == timeLatch_ff[63:32];
  endproperty
  a_tag_order: assert property (p_tag_order)
    else $error("time tag words out of order");
  property p_hi_zero;
    @(posedge sys_clk) disable iff (!rst_n)
      s_hi_loaded and !absTimeSel |=> bodyData[31:16] == 16'h0000;
  endproperty
  a_hi_zero: assert property (p_hi_zero)
    else $error("counter tag high half not zero");
  property p_ext_range;
    @(posedge sys_clk) disable iff (!rst_n)
      scrExt_ff < `VFP_SCR_EXT_MOD;
  endproperty
  a_ext_range: assert property (p_ext_range)
    else $error("stream clock extension out of range");

  // combined value lags base and extension by one cycle
  property p_scr_step;
    @(posedge sys_clk) disable iff (!rst_n)
      ctrl_ff[`VFP_CTRL_SCR_EN] && rtcTick && scrExt_ff < 9'd290 |=>
        scrExt_ff - $past(scrExt_ff) inside {9'd2, 9'd3} ##1
        scrValue_ff == 42'($past(scrBase_ff)) * 42'd300 +
        42'($past(scrExt_ff));
  endproperty
  a_scr_step: assert property (p_scr_step)
    else $error("stream clock step wrong");
  // only a freshly loaded last word is checked, not one held by the sink
  property p_whole_units;
    @(posedge sys_clk) disable iff (!rst_n)
      bodyValid && bodyLast && $past(canLoad) |->
        $past(unitLast) && $past(unitTake);
  endproperty
  a_whole_units: assert property (p_whole_units)
    else $error("packet closed inside a unit");

endmodule : vfp_packet_framer

/* sim/vfp_body_sink.sv */
`timescale 1ns/1ps
module vfp_body_sink (
  input  wire logic sys_clk,
  input  wire logic rst_n,
  input  wire logic stall,
  input  wire logic bodyValid,
  input  wire logic bodyFirst,
  input  wire logic bodyLast,
  output logic      bodyReady,
  output logic      frameErr
);
  logic inPkt_ff;
  // slow mode drops ready at random so the body hold gets exercised
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      bodyReady <= 1'b0;
    end else begin
      bodyReady <= stall ? 1'($urandom % 2) : 1'b1;
    end
  end
  // descriptor opens a body, last word closes it
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      inPkt_ff <= 1'b0;
      frameErr <= 1'b0;
    end else if (bodyValid && bodyReady) begin
      if (inPkt_ff == bodyFirst) frameErr <= 1'b1;
      inPkt_ff <= !bodyLast;
    end
  end
endmodule : vfp_body_sink

/* sim/video_format2_packet_framer_bench.sv */
`timescale 1ns/1ps
`include "vfp_regs.svh"
module video_format2_packet_framer_bench;
  logic        sys_clk, rst_n, psel, penable, pwrite, pready, pslverr;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, unitData, bodyData, cfg, desc, dw;
  logic        unitValid, unitReady, unitLast, unitPktEnd, rtcTick;
  logic        bodyValid, bodyReady, bodyFirst, bodyLast, absTimeSel;
  logic        stall, frameErr, hdr, abs, scr, last;
  logic [47:0] rtcTime;
  logic [63:0] absTime, tm;
  logic [1:0]  timeFormat, fmt;
  logic [32:0] scrBase;
  logic [8:0]  scrExt;
  logic [41:0] scrValue, sv;
  logic [11:0] units;
  logic [33:0] expQ[$];
  int          n_fail, checked, cycles, nu, nw;

  vfp_packet_framer DUT (
    .sys_clk(sys_clk), .rst_n(rst_n), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .unitValid(unitValid),
    .unitReady(unitReady), .unitData(unitData), .unitLast(unitLast),
    .unitPktEnd(unitPktEnd), .bodyValid(bodyValid),
    .bodyReady(bodyReady), .bodyData(bodyData), .bodyFirst(bodyFirst),
    .bodyLast(bodyLast), .rtcTick(rtcTick), .rtcTime(rtcTime),
    .absTime(absTime), .absTimeSel(absTimeSel),
    .timeFormat(timeFormat), .scrBase(scrBase), .scrExt(scrExt),
    .scrValue(scrValue)
  );

  vfp_body_sink sink (
    .sys_clk(sys_clk), .rst_n(rst_n), .stall(stall),
    .bodyValid(bodyValid), .bodyFirst(bodyFirst), .bodyLast(bodyLast),
    .bodyReady(bodyReady), .frameErr(frameErr)
  );

  initial begin
    sys_clk = 1'b0;
    forever #20 sys_clk = ~sys_clk;
  end

  task chk(input string nm, input logic [63:0] seen, input logic [63:0] exp);
    checked++;
    if (seen !== exp) begin
      n_fail++;
      $display("wrong value %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk

  task give_verdict;
    if (n_fail == 0 && checked > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : give_verdict

  // apb transfer; one idle edge after release keeps strobes single-driven
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d,
           output logic [32:0] r);
    int n;
    n = 0;
    psel   <= 1'b1;
    pwrite <= w;
    paddr  <= a;
    pwdata <= d;
    @(posedge sys_clk);
    penable <= 1'b1;
    do begin
      @(posedge sys_clk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (n == 50) n_fail++;
    r = {pslverr, prdata};
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge sys_clk);
  endtask : apb

  task wr(input logic [7:0] a, input logic [31:0] d);
    logic [32:0] r;
    apb(1'b1, a, d, r);
  endtask : wr

  task rd(input logic [7:0] a, input logic [32:0] exp);
    logic [32:0] r;
    apb(1'b0, a, 32'h0, r);
    chk("register", 64'(r), 64'(exp));
  endtask : rd

  task tick;
    rtcTick <= 1'b1;
    @(posedge sys_clk);
    rtcTick <= 1'b0;
    @(posedge sys_clk);
  endtask : tick

  task send_word(input logic [31:0] d, input logic l, input logic e);
    int n;
    n = 0;
    unitValid  <= 1'b1;
    unitData   <= d;
    unitLast   <= l;
    unitPktEnd <= e;
    do begin
      @(posedge sys_clk);
      n++;
    end while (unitReady !== 1'b1 && n < 200);
    if (n == 200) n_fail++;
  endtask : send_word

  always @(posedge sys_clk) begin
    if (rst_n && bodyValid === 1'b1 && bodyReady === 1'b1) begin
      chk("body", 64'({bodyFirst, bodyLast, bodyData}),
          expQ.size() != 0 ? 64'(expQ.pop_front()) : 'x);
    end
  end

  // ceiling well above the roughly 3000 cycles the run needs
  always @(posedge sys_clk) begin
    cycles++;
    if (cycles == 60000) begin
      n_fail++;
      give_verdict();
    end
  end

  initial begin
    {psel, penable, pwrite, paddr, pwdata, rtcTick, stall} = '0;
    {unitValid, unitData, unitLast, unitPktEnd, rtcTime, absTime} = '0;
    rst_n = 1'b0;
    void'($urandom(32'h5f69));
    repeat (2) @(posedge sys_clk);
    rst_n <= 1'b1;
    @(posedge sys_clk);
    rd(`VFP_OFF_CTRL, 33'h0);
    rd(`VFP_OFF_STATUS, 33'h1);
    rd(8'h1C, {1'b1, 32'h0});
    wr(`VFP_OFF_DESC_CFG, 32'hFFFF_FFFF);
    rd(`VFP_OFF_DESC_CFG, {1'b0, `VFP_DESC_CFG_MASK});
    rd(`VFP_OFF_STATUS, 33'h21);
    wr(`VFP_OFF_STATUS, 32'h0000_0020);
    rd(`VFP_OFF_STATUS, 33'h1);
    // disabled framer must leave the offered word alone
    unitValid <= 1'b1;
    repeat (20) begin
      @(posedge sys_clk);
      chk("idle", 64'({unitReady, bodyValid}), 64'h0);
    end
    unitValid <= 1'b0;
    wr(`VFP_OFF_CTRL, 32'h0000_0020);
    for (int k = 0; k < 1000; k++) begin
      tick();
      if (k == 9 || k == 99 || k == 999) begin
        repeat (3) @(posedge sys_clk);
        sv = 42'((k + 1) * 27 / 10);
        chk("scr", 64'(scrValue), 64'(sv));
        chk("scr base", 64'(scrBase), 64'(sv / 300));
        chk("scr ext", 64'(scrExt), 64'(sv % 300));
        chk("scr ticks", 64'((sv * 10 + 13) / 27), 64'(k + 1));
        rd(`VFP_OFF_SCR_LO, {1'b0, sv[31:0]});
      end
    end
    for (int p = 0; p < 24; p++) begin
      {hdr, abs, scr, fmt} = 5'($urandom);
      cfg = $urandom;
      cfg[25:22] = 4'(p);
      cfg[18:15] = 4'(p % 9);
      units = 12'($urandom % 4);
      stall <= 1'($urandom);
      wr(`VFP_OFF_CTRL, {26'h0, scr, fmt, abs, hdr, 1'b1});
      wr(`VFP_OFF_DESC_CFG, cfg);
      wr(`VFP_OFF_UNITS, {20'h0, units});
      chk("tsel", 64'({absTimeSel, timeFormat}), 64'({abs, fmt}));
      desc = cfg & `VFP_DESC_CFG_MASK;
      if (desc[18:15] > 4'h6) desc[18:15] = 4'h0;
      desc[20] = scr;
      desc[19] = hdr;
      desc[11:0] = units;
      expQ.push_back({2'b10, desc});
      nu = units == 0 ? 1 + $urandom % 3 : int'(units);
      for (int u = 0; u < nu; u++) begin
        nw = 1 + $urandom % 3;
        tm = {$urandom, $urandom};
        rtcTime <= tm[47:0];
        absTime <= tm;
        if (hdr) begin
          expQ.push_back({2'b00, tm[31:0]});
          expQ.push_back({2'b00, abs ? tm[63:32] : {16'h0, tm[47:32]}});
        end
        for (int w = 0; w < nw; w++) begin
          dw = $urandom;
          last = (u == nu - 1) && (w == nw - 1);
          expQ.push_back({1'b0, last, dw});
          send_word(dw, w == nw - 1, last && units == 0);
        end
      end
      unitValid <= 1'b0;
      for (int k = 0; k < 400 && expQ.size() != 0; k++) @(posedge sys_clk);
      chk("drained", 64'(expQ.size()), 64'h0);
    end
    rd(`VFP_OFF_PKT_CNT, 33'h18);
    chk("framing", 64'(frameErr), 64'h0);
    give_verdict();
  end
endmodule : video_format2_packet_framer_bench
